// [core/epr_route_select.sv]
`timescale 1ns/1ps
`default_nettype none
module epr_route_select
  import epr_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // cpu i/o space port
  input  wire epr_io_req_t       ioReq,
  output logic      [15:0]       ioRdata,
  // parallel port pads
  input  wire logic [27:0]       ppPadIn,
  output logic      [27:0]       ppPadOut,
  output logic      [27:0]       ppPadOe,
  // serial port 1 pads
  input  wire logic [5:0]        sp1PadIn,
  output logic      [5:0]        sp1PadOut,
  output logic      [5:0]        sp1PadOe,
  // serial port 0 pads
  input  wire logic [5:0]        sp0PadIn,
  output logic      [5:0]        sp0PadOut,
  output logic      [5:0]        sp0PadOe,
  // upper address pads
  input  wire logic [5:0]        addrPadIn,
  output logic      [5:0]        addrPadOut,
  output logic      [5:0]        addrPadOe,
  // host port
  input  wire logic [27:0]       hostOut,
  input  wire logic [27:0]       hostOe,
  output logic      [27:0]       hostIn,
  // sdram control of ext_mem_if
  input  wire logic [6:0]        sdramOut,
  input  wire logic [6:0]        sdramOe,
  output logic      [6:0]        sdramIn,
  // spi
  input  wire logic [6:0]        spiOut,
  input  wire logic [6:0]        spiOe,
  output logic      [6:0]        spiIn,
  // parallel port gpio_line group
  input  wire logic [7:0]        ppGpioOut,
  input  wire logic [7:0]        ppGpioOe,
  output logic      [7:0]        ppGpioIn,
  // uart
  input  wire logic [3:0]        uartOut,
  input  wire logic [3:0]        uartOe,
  output logic      [3:0]        uartIn,
  // i2s channel 2
  input  wire logic [3:0]        i2s2Out,
  input  wire logic [3:0]        i2s2Oe,
  output logic      [3:0]        i2s2In,
  // i2s channel 3
  input  wire logic [3:0]        i2s3Out,
  input  wire logic [3:0]        i2s3Oe,
  output logic      [3:0]        i2s3In,
  // memory card interface 1
  input  wire logic [5:0]        card1Out,
  input  wire logic [5:0]        card1Oe,
  output logic      [5:0]        card1In,
  // multichannel_spi
  input  wire logic [5:0]        mcspiOut,
  input  wire logic [5:0]        mcspiOe,
  output logic      [5:0]        mcspiIn,
  // gpio_line 11..6
  input  wire logic [5:0]        gpioHiOut,
  input  wire logic [5:0]        gpioHiOe,
  output logic      [5:0]        gpioHiIn,
  // memory card interface 0
  input  wire logic [5:0]        card0Out,
  input  wire logic [5:0]        card0Oe,
  output logic      [5:0]        card0In,
  // i2s channel 0
  input  wire logic [3:0]        i2s0Out,
  input  wire logic [3:0]        i2s0Oe,
  output logic      [3:0]        i2s0In,
  // gpio_line 5..0
  input  wire logic [5:0]        gpioLoOut,
  input  wire logic [5:0]        gpioLoOe,
  output logic      [5:0]        gpioLoIn,
  // buffered_serial_port, lane 5 is bsp_receive_clock
  input  wire logic [5:0]        bspOut,
  input  wire logic [5:0]        bspOe,
  output logic      [5:0]        bspIn,
  output logic                   bsp_source_clock,
  // ext_mem_addr 20..15 and gpio_line 26..21
  input  wire logic [5:0]        ext_mem_addr,
  input  wire logic [5:0]        addrGpioOut,
  input  wire logic [5:0]        addrGpioOe,
  output logic      [5:0]        addrGpioIn
);

  localparam int PPW = EPR_PP_MODES * EPR_PP_PINS;
  localparam int SPW1 = EPR_SP1_MODES * EPR_SP_PINS;
  localparam int SPW0 = EPR_SP0_MODES * EPR_SP_PINS;

  epr_ctrl_t   external_pin_route_ctrl;
  epr_ctrl_t   next_ctrl;
  logic [15:0] next_ioRdata;
  logic        regHit;

  // register access; writes land at the edge that takes them
  always_comb begin
    regHit       = ioReq.strobe && (ioReq.addr == EPR_CTRL_ADDR);
    next_ctrl    = external_pin_route_ctrl;
    next_ioRdata = '0;
    if (regHit && ioReq.write) begin
      // (RULE21) reserved bits masked
      next_ctrl = epr_ctrl_t'((16'(external_pin_route_ctrl) & ~EPR_WRITE_MASK)
                              | (ioReq.wdata & EPR_WRITE_MASK));
    end
    if (regHit && !ioReq.write) begin
      next_ioRdata = 16'(external_pin_route_ctrl);
    end
  end

  // (RULE23) reset value
  always_ff @(posedge clock) begin
    if (rst) begin
      external_pin_route_ctrl <= epr_ctrl_t'(EPR_CTRL_RESET);
      ioRdata                 <= '0;
    end else begin
      external_pin_route_ctrl <= next_ctrl;
      ioRdata                 <= next_ioRdata;
    end
  end

  // parallel port candidates, sdram control in lanes 6..0 of modes 1 to 6
  logic [PPW-1:0] ppSrcOut;
  logic [PPW-1:0] ppSrcOe;
  logic [PPW-1:0] ppSink;

  always_comb begin
    // (RULE7) host port owns all pins
    ppSrcOut[0*28 +: 28] = hostOut;
    ppSrcOe[0*28 +: 28]  = hostOe;
    // (RULE8) mode 1 layout
    ppSrcOut[1*28 +: 28] = {i2s2Out, uartOut, ppGpioOut[5:0], spiOut, sdramOut};
    ppSrcOe[1*28 +: 28]  = {i2s2Oe, uartOe, ppGpioOe[5:0], spiOe, sdramOe};
    // (RULE9) mode 2 layout
    ppSrcOut[2*28 +: 28] = {13'h0000, ppGpioOut, sdramOut};
    ppSrcOe[2*28 +: 28]  = {13'h0000, ppGpioOe, sdramOe};
    // (RULE10) mode 3 layout
    ppSrcOut[3*28 +: 28] = {13'h0000, i2s3Out, spiOut[3:0], sdramOut};
    ppSrcOe[3*28 +: 28]  = {13'h0000, i2s3Oe, spiOe[3:0], sdramOe};
    // (RULE11) mode 4 layout
    ppSrcOut[4*28 +: 28] = {13'h0000, uartOut, i2s2Out, sdramOut};
    ppSrcOe[4*28 +: 28]  = {13'h0000, uartOe, i2s2Oe, sdramOe};
    // (RULE12) mode 5 layout
    ppSrcOut[5*28 +: 28] = {13'h0000, uartOut, spiOut[3:0], sdramOut};
    ppSrcOe[5*28 +: 28]  = {13'h0000, uartOe, spiOe[3:0], sdramOe};
    // (RULE13) mode 6 layout
    ppSrcOut[6*28 +: 28] = {i2s3Out, i2s2Out, ppGpioOut[5:0], spiOut, sdramOut};
    ppSrcOe[6*28 +: 28]  = {i2s3Oe, i2s2Oe, ppGpioOe[5:0], spiOe, sdramOe};
  end

  // (RULE1) pads follow register next cycle
  epr_pin_mux #(.W(EPR_PP_PINS), .N(EPR_PP_MODES), .SW(3)) ppMux (
    .clock  (clock),
    .rst    (rst),
    .sel    (external_pin_route_ctrl.parallel_port_route),
    .srcOut (ppSrcOut),
    .srcOe  (ppSrcOe),
    .padIn  (ppPadIn),
    .padOut (ppPadOut),
    .padOe  (ppPadOe),
    .sinkIn (ppSink)
  );

  // serial port 1 candidates
  logic [SPW1-1:0] sp1Sink;

  // (RULE14) card 1, (RULE15) multichannel_spi, (RULE16) gpio 11..6
  epr_pin_mux #(.W(EPR_SP_PINS), .N(EPR_SP1_MODES), .SW(2)) sp1Mux (
    .clock  (clock),
    .rst    (rst),
    .sel    (external_pin_route_ctrl.serial_port1_route),
    .srcOut ({gpioHiOut, mcspiOut, card1Out}),
    .srcOe  ({gpioHiOe, mcspiOe, card1Oe}),
    .padIn  (sp1PadIn),
    .padOut (sp1PadOut),
    .padOe  (sp1PadOe),
    .sinkIn (sp1Sink)
  );

  // serial port 0; extra slot 4 leaves the clock pin to the source clock
  logic [SPW0-1:0] sp0Src;
  logic [SPW0-1:0] sp0SrcOe;
  logic [SPW0-1:0] sp0Sink;
  logic [2:0]      sp0Sel;

  always_comb begin
    // (RULE17) card 0
    sp0Src[0*6 +: 6]   = card0Out;
    sp0SrcOe[0*6 +: 6] = card0Oe;
    // (RULE18) i2s0 plus gpio 5..4
    sp0Src[1*6 +: 6]   = {gpioLoOut[5:4], i2s0Out};
    sp0SrcOe[1*6 +: 6] = {gpioLoOe[5:4], i2s0Oe};
    // (RULE19) gpio 5..0
    sp0Src[2*6 +: 6]   = gpioLoOut;
    sp0SrcOe[2*6 +: 6] = gpioLoOe;
    // (RULE20) buffered serial port
    sp0Src[3*6 +: 6]   = bspOut;
    sp0SrcOe[3*6 +: 6] = bspOe;
    // clock pin becomes an input for the source clock
    sp0Src[4*6 +: 6]   = {1'b0, bspOut[4:0]};
    sp0SrcOe[4*6 +: 6] = {1'b0, bspOe[4:0]};
    // (RULE6) clock pin select
    if (external_pin_route_ctrl.serial_port0_route == EPR_SP0_BSP
        && external_pin_route_ctrl.clkSel) begin
      sp0Sel = EPR_SP0_BSP_SRC;
    end else begin
      sp0Sel = {1'b0, external_pin_route_ctrl.serial_port0_route};
    end
  end

  epr_pin_mux #(.W(EPR_SP_PINS), .N(EPR_SP0_MODES), .SW(3)) sp0Mux (
    .clock  (clock),
    .rst    (rst),
    .sel    (sp0Sel),
    .srcOut (sp0Src),
    .srcOe  (sp0SrcOe),
    .padIn  (sp0PadIn),
    .padOut (sp0PadOut),
    .padOe  (sp0PadOe),
    .sinkIn (sp0Sink)
  );

  // upper address pads, one two-way mux per pin
  logic [1:0] addrSink [EPR_ADDR_PINS];

  genvar g;
  generate
    for (g = 0; g < EPR_ADDR_PINS; g++) begin : gAddr
      logic [1:0] aSink;
      // (RULE2) 1 selects gpio, (RULE3) 0 selects address output
      epr_pin_mux #(.W(1), .N(2), .SW(1)) addrMux (
        .clock  (clock),
        .rst    (rst),
        .sel    (external_pin_route_ctrl.addrPinSelect[g]),
        .srcOut ({addrGpioOut[g], ext_mem_addr[g]}),
        .srcOe  ({addrGpioOe[g], 1'b1}),
        .padIn  (addrPadIn[g]),
        .padOut (addrPadOut[g]),
        .padOe  (addrPadOe[g]),
        .sinkIn (aSink)
      );
      assign addrSink[g] = aSink;
    end
  endgenerate

  // peripheral inputs gathered from whichever mode owns each lane
  logic [27:0] next_hostIn;
  logic [6:0]  next_sdramIn;
  logic [6:0]  next_spiIn;
  logic [7:0]  next_ppGpioIn;
  logic [3:0]  next_uartIn;
  logic [3:0]  next_i2s2In;
  logic [3:0]  next_i2s3In;
  logic [5:0]  next_addrGpioIn;

  always_comb begin
    next_hostIn   = ppSink[0*28 +: 28];
    next_sdramIn  = '0;
    for (int m = 1; m < EPR_PP_MODES; m++) begin
      next_sdramIn = next_sdramIn | ppSink[m*28 +: 7];
    end
    next_spiIn    = ppSink[1*28+7 +: 7] | ppSink[6*28+7 +: 7]
                  | {3'h0, ppSink[3*28+7 +: 4]} | {3'h0, ppSink[5*28+7 +: 4]};
    next_ppGpioIn = {2'h0, ppSink[1*28+14 +: 6]} | ppSink[2*28+7 +: 8]
                  | {2'h0, ppSink[6*28+14 +: 6]};
    next_uartIn   = ppSink[1*28+20 +: 4] | ppSink[4*28+11 +: 4]
                  | ppSink[5*28+11 +: 4];
    next_i2s2In   = ppSink[1*28+24 +: 4] | ppSink[4*28+7 +: 4]
                  | ppSink[6*28+20 +: 4];
    next_i2s3In   = ppSink[3*28+11 +: 4] | ppSink[6*28+24 +: 4];
    for (int a = 0; a < EPR_ADDR_PINS; a++) begin
      next_addrGpioIn[a] = addrSink[a][1];
    end
  end

  // (RULE22) reset leaves address pads undriven
  always_ff @(posedge clock) begin
    if (rst) begin
      hostIn           <= '0;
      sdramIn          <= '0;
      spiIn            <= '0;
      ppGpioIn         <= '0;
      uartIn           <= '0;
      i2s2In           <= '0;
      i2s3In           <= '0;
      card1In          <= '0;
      mcspiIn          <= '0;
      gpioHiIn         <= '0;
      card0In          <= '0;
      i2s0In           <= '0;
      gpioLoIn         <= '0;
      bspIn            <= '0;
      bsp_source_clock <= 1'b0;
      addrGpioIn       <= '0;
    end else begin
      hostIn           <= next_hostIn;
      sdramIn          <= next_sdramIn;
      spiIn            <= next_spiIn;
      ppGpioIn         <= next_ppGpioIn;
      uartIn           <= next_uartIn;
      i2s2In           <= next_i2s2In;
      i2s3In           <= next_i2s3In;
      card1In          <= sp1Sink[0*6 +: 6];
      mcspiIn          <= sp1Sink[1*6 +: 6];
      gpioHiIn         <= sp1Sink[2*6 +: 6];
      card0In          <= sp0Sink[0*6 +: 6];
      i2s0In           <= sp0Sink[1*6 +: 4];
      gpioLoIn         <= sp0Sink[2*6 +: 6] | {sp0Sink[1*6+4 +: 2], 4'h0};
      bspIn            <= sp0Sink[3*6 +: 6] | {1'b0, sp0Sink[4*6 +: 5]};
      bsp_source_clock <= sp0Sink[4*6 + EPR_SP0_CLK_LANE];
      addrGpioIn       <= next_addrGpioIn;
    end
  end

endmodule // epr_route_select
`default_nettype wire

// [core/epr_pkg.sv]
// Operation
// (RULE1) new routing reaches the pins on the cycle after the register write
// (RULE2) address pin select bit at 1 makes that pin a general-purpose line
// (RULE3) address pin select bit at 0 makes that pin an address output
// (RULE4) software gates clocks of affected peripherals before changing routing
// (RULE5) software resets affected peripherals after changing routing, before use
// (RULE6) bit 15 picks receive clock or source clock on serial port 0 mode 3
// (RULE7) parallel field 000 gives all 28 pins to host port, no SDRAM
// (RULE8) parallel 001 routes SPI 7, GPIO 6, UART 4, I2S2 4, SDRAM 7
// (RULE9) parallel 010 routes GPIO 8 and SDRAM control 7
// (RULE10) parallel 011 routes SPI 4, I2S3 4, SDRAM control 7
// (RULE11) parallel 100 routes I2S2 4, UART 4, SDRAM control 7
// (RULE12) parallel 101 routes SPI 4, UART 4, SDRAM control 7
// (RULE13) parallel 110 routes SPI 7, I2S2, I2S3, GPIO 6, SDRAM; 111 reserved
// (RULE14) serial port 1 field 00 routes memory card interface 1
// (RULE15) serial port 1 field 01 routes multichannel SPI; 11 reserved
// (RULE16) serial port 1 field 10 routes general-purpose lines 11 to 6
// (RULE17) serial port 0 field 00 routes memory card interface 0
// (RULE18) serial port 0 field 01 routes I2S0 4 plus general-purpose lines 5, 4
// (RULE19) serial port 0 field 10 routes general-purpose lines 5 to 0
// (RULE20) serial port 0 field 11 routes the buffered serial port
// (RULE21) bits 7 and 6 read zero and ignore writes
// (RULE22) after reset all six address pins are general-purpose inputs
// (RULE23) selection register resets to 0x103f
package epr_pkg;

  // register location in cpu i/o space
  localparam logic [15:0] EPR_CTRL_ADDR  = 16'h1c00;
  localparam logic [15:0] EPR_CTRL_RESET = 16'h103f;
  // writable bits; 7:6 are held at zero
  localparam logic [15:0] EPR_WRITE_MASK = 16'hff3f;

  // field positions
  localparam int EPR_CLKSEL_POS = 15;
  localparam int EPR_PP_POS     = 12;
  localparam int EPR_SP1_POS    = 10;
  localparam int EPR_SP0_POS    = 8;
  localparam int EPR_ADDR_POS   = 0;

  // pin group widths
  localparam int EPR_PP_PINS   = 28;
  localparam int EPR_SP_PINS   = 6;
  localparam int EPR_ADDR_PINS = 6;
  localparam int EPR_SDRAM_W   = 7;

  // parallel port candidates (111 reserved)
  localparam int EPR_PP_MODES  = 7;
  // serial port 1 candidates (11 reserved)
  localparam int EPR_SP1_MODES = 3;
  // serial port 0: four modes plus mode 3 with source clock
  localparam int EPR_SP0_MODES = 5;
  localparam logic [1:0] EPR_SP0_BSP     = 2'h3;
  localparam logic [2:0] EPR_SP0_BSP_SRC = 3'h4;
  // lane of the shared serial port 0 clock pin
  localparam int EPR_SP0_CLK_LANE = 5;

  // selection register layout
  typedef struct packed {
    logic       clkSel;
    logic [2:0] parallel_port_route;
    logic [1:0] serial_port1_route;
    logic [1:0] serial_port0_route;
    logic [1:0] reserved;
    logic [5:0] addrPinSelect;
  } epr_ctrl_t;

  // cpu i/o space access
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } epr_io_req_t;

endpackage

// [core/epr_pin_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module epr_pin_mux
  import epr_pkg::*;
#(
  parameter int W  = 6,
  parameter int N  = 4,
  parameter int SW = 2
) (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // candidate selection
  input  wire logic [SW-1:0]  sel,
  // candidate sources, W lanes each
  input  wire logic [N*W-1:0] srcOut,
  input  wire logic [N*W-1:0] srcOe,
  // pads
  input  wire logic [W-1:0]   padIn,
  output logic      [W-1:0]   padOut,
  output logic      [W-1:0]   padOe,
  // synchronised pad level, delivered only to the chosen source
  output logic      [N*W-1:0] sinkIn
);

  logic [W-1:0] syncA;
  logic [W-1:0] syncB;
  logic [W-1:0] next_padOut;
  logic [W-1:0] next_padOe;

  // an unlisted select leaves every pad undriven and feeds no one
  always_comb begin
    next_padOut = '0;
    next_padOe  = '0;
    sinkIn      = '0;
    for (int i = 0; i < N; i++) begin
      if (sel == SW'(i)) begin
        next_padOut           = srcOut[i*W +: W];
        next_padOe            = srcOe[i*W +: W];
        sinkIn[i*W +: W]      = syncB;
      end
    end
  end

  // pad drive and two-stage input synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      padOut <= '0;
      padOe  <= '0;
      syncA  <= '0;
      syncB  <= '0;
    end else begin
      padOut <= next_padOut;
      padOe  <= next_padOe;
      syncA  <= padIn;
      syncB  <= syncA;
    end
  end

endmodule // epr_pin_mux
`default_nettype wire

// [sim/epr_route_select_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module epr_route_select_assertions
  import epr_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register port
  input wire epr_io_req_t ioReq,
  input wire logic [15:0] ioRdata,
  // parallel port
  input wire logic [27:0] ppPadOut,
  input wire logic [27:0] ppPadOe,
  input wire logic [27:0] hostOut,
  // serial port 0
  input wire logic [5:0]  sp0PadOe,
  // upper address pins
  input wire logic [5:0]  addrPadOut,
  input wire logic [5:0]  addrPadOe,
  input wire logic [5:0]  ext_mem_addr,
  input wire logic [5:0]  addrGpioOut,
  input wire logic [5:0]  addrGpioOe
);
  logic        rdReq;
  logic        wrReq;
  logic        live;
  logic [15:0] shadow;
  logic [15:0] next_shadow;
  logic [15:0] prev;

  // bus decode for the selection register
  assign rdReq = ioReq.strobe && !ioReq.write && ioReq.addr == EPR_CTRL_ADDR;
  assign wrReq = ioReq.strobe && ioReq.write && ioReq.addr == EPR_CTRL_ADDR;

  // shadow built from the bus alone, so a stuck register shows up
  always_comb begin
    next_shadow = shadow;
    if (wrReq) begin
      next_shadow = ioReq.wdata & EPR_WRITE_MASK;
    end
    if (rst) begin
      next_shadow = EPR_CTRL_RESET;
    end
  end

  // live is low on the first edge after reset, when pads still hold reset values
  always_ff @(posedge clock) begin
    shadow <= next_shadow;
    prev   <= shadow;
    live   <= !rst;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_read; rdReq; endsequence
  sequence s_claim; wrReq && ioReq.wdata[5:0] == 6'h00; endsequence

  property p_read_data; s_read |=> ioRdata == $past(shadow); endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differs from register");
  property p_reserved_zero; s_read |=> ioRdata[7:6] == 2'h0; endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");
  property p_read_idle; !rdReq |=> ioRdata == 16'h0000; endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data left standing");
  property p_next_cycle; s_claim ##1 1'b1 |=> addrPadOe == 6'h3f; endproperty
  a_next_cycle: assert property (p_next_cycle)
    else $error("address routing late");
  property p_ext_mem_if_pins;
    live |-> ((addrPadOe | prev[5:0]) == 6'h3f)
      && ((addrPadOut & ~prev[5:0]) == ($past(ext_mem_addr) & ~prev[5:0]));
  endproperty
  a_ext_mem_if_pins: assert property (p_ext_mem_if_pins)
    else $error("address pin not driving address");
  property p_gpio_pins;
    live |-> ((addrPadOe & prev[5:0]) == ($past(addrGpioOe) & prev[5:0]))
      && ((addrPadOut & prev[5:0]) == ($past(addrGpioOut) & prev[5:0]));
  endproperty
  a_gpio_pins: assert property (p_gpio_pins)
    else $error("address pin not following gpio");
  property p_reset_inputs; $fell(rst) |-> addrPadOe == 6'h00; endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("address pin driven out of reset");
  property p_host_port; live && prev[14:12] == 3'h0 |-> ppPadOut == $past(hostOut); endproperty
  a_host_port: assert property (p_host_port)
    else $error("parallel port not host");
  property p_reserved_pp; live && prev[14:12] == 3'h7 |-> ppPadOe == 28'h0; endproperty
  a_reserved_pp: assert property (p_reserved_pp)
    else $error("reserved parallel mode drives");
  property p_source_clock; live && prev[15] && prev[9:8] == 2'h3 |-> !sp0PadOe[5]; endproperty
  a_source_clock: assert property (p_source_clock)
    else $error("clock pin driven in source mode");
endmodule // epr_route_select_assertions

bind epr_route_select epr_route_select_assertions epr_chk_i (.*);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import epr_pkg::*;
;
  logic        clock;
  logic        rst;
  epr_io_req_t ioReq;
  logic [15:0] ioRdata;
  logic [27:0] ppPadIn, ppPadOut, ppPadOe, hostOut, hostOe, hostIn;
  logic [6:0]  sdramOut, sdramOe, sdramIn, spiOut, spiOe, spiIn;
  logic [7:0]  ppGpioOut, ppGpioOe, ppGpioIn;
  logic [5:0]  sp1PadIn, sp1PadOut, sp1PadOe, sp0PadIn, sp0PadOut, sp0PadOe;
  logic [5:0]  addrPadIn, addrPadOut, addrPadOe, card1Out, card1Oe, card1In;
  logic [5:0]  mcspiOut, mcspiOe, mcspiIn, gpioHiOut, gpioHiOe, gpioHiIn;
  logic [5:0]  card0Out, card0Oe, card0In, gpioLoOut, gpioLoOe, gpioLoIn;
  logic [5:0]  bspOut, bspOe, bspIn, ext_mem_addr, addrGpioOut, addrGpioOe, addrGpioIn;
  logic [3:0]  uartOut, uartOe, uartIn, i2s2Out, i2s2Oe, i2s2In;
  logic [3:0]  i2s3Out, i2s3Oe, i2s3In, i2s0Out, i2s0Oe, i2s0In;
  logic        bsp_source_clock;
  logic [287:0] pool;
  logic [15:0]  regVal;
  integer       seed;
  int           err_total;
  int           n_tests;

  epr_route_select epr_route_select_i (.*);

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // one compare, counted
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  // request held until the taking edge; caller decides on release
  task automatic io(input logic w, input logic [15:0] a, input logic [15:0] d);
    ioReq <= '{1'b1, w, a, d};
    @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    io(1'b1, a, d);
    ioReq <= '0;
    @(posedge clock);
  endtask

  // read data stands for one cycle only, so it is looked at right away
  task automatic rd(input logic [15:0] a, input logic [15:0] want);
    io(1'b0, a, 16'h0000);
    ioReq <= '0;
    #1;
    chk(64'(ioRdata), 64'(want));
    @(posedge clock);
  endtask

  task automatic rstPulse();
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // all pad and peripheral inputs from the random pool
  task automatic drive();
    {ppPadIn, sp1PadIn, sp0PadIn, addrPadIn, hostOut, hostOe, sdramOut, sdramOe, spiOut,
     spiOe, ppGpioOut, ppGpioOe, uartOut, uartOe, i2s2Out, i2s2Oe, i2s3Out, i2s3Oe,
     card1Out, card1Oe, mcspiOut, mcspiOe, gpioHiOut, gpioHiOe, card0Out, card0Oe,
     i2s0Out, i2s0Oe, gpioLoOut, gpioLoOe, bspOut, bspOe, ext_mem_addr, addrGpioOut,
     addrGpioOe} <= pool[267:0];
  endtask

  // expected parallel lanes for one mode
  function automatic logic [27:0] ppMap(input logic [2:0] m, input logic [27:0] h,
      input logic [6:0] d, s, input logic [7:0] g, input logic [3:0] u, a, b);
    case (m)
      3'h0: return h;
      3'h1: return {a, u, g[5:0], s, d};
      3'h2: return {13'h0, g, d};
      3'h3: return {13'h0, b, s[3:0], d};
      3'h4: return {13'h0, u, a, d};
      3'h5: return {13'h0, u, s[3:0], d};
      3'h6: return {b, a, g[5:0], s, d};
      default: return 28'h0;
    endcase
  endfunction

  function automatic logic [5:0] sp1Map(input logic [1:0] m, input logic [5:0] k, s, g);
    return (m == 2'h0) ? k : (m == 2'h1) ? s : (m == 2'h2) ? g : 6'h00;
  endfunction

  // clock pin lane is released when the source clock is picked
  function automatic logic [5:0] sp0Map(input logic [1:0] m, input logic c,
      input logic [5:0] k, input logic [3:0] i, input logic [5:0] g, p);
    case (m)
      2'h0: return k;
      2'h1: return {g[5:4], i};
      2'h2: return g;
      default: return c ? {1'b0, p[4:0]} : p;
    endcase
  endfunction

  // expected {spi, gpio, uart, i2s2, i2s3} inputs for one parallel mode
  function automatic logic [26:0] ppIn(input logic [2:0] m, input logic [27:0] p);
    case (m)
      3'h1: return {p[13:7], 2'h0, p[19:14], p[23:20], p[27:24], 4'h0};
      3'h2: return {7'h0, p[14:7], 12'h0};
      3'h3: return {3'h0, p[10:7], 16'h0, p[14:11]};
      3'h4: return {15'h0, p[14:11], p[10:7], 4'h0};
      3'h5: return {3'h0, p[10:7], 8'h0, p[14:11], 8'h0};
      3'h6: return {p[13:7], 2'h0, p[19:14], 4'h0, p[23:20], p[27:24]};
      default: return 27'h0;
    endcase
  endfunction

  // every pad and peripheral input against the routing in c
  task automatic check(input logic [15:0] c);
    logic [27:0] po, pv;
    logic [5:0]  s, s1, s0, v1, v0;
    s  = c[5:0];
    po = ppMap(c[14:12], hostOe, sdramOe, spiOe, ppGpioOe, uartOe, i2s2Oe, i2s3Oe);
    pv = ppMap(c[14:12], hostOut, sdramOut, spiOut, ppGpioOut, uartOut, i2s2Out, i2s3Out);
    s1 = sp1Map(c[11:10], card1Oe, mcspiOe, gpioHiOe);
    v1 = sp1Map(c[11:10], card1Out, mcspiOut, gpioHiOut);
    s0 = sp0Map(c[9:8], c[15], card0Oe, i2s0Oe, gpioLoOe, bspOe);
    v0 = sp0Map(c[9:8], c[15], card0Out, i2s0Out, gpioLoOut, bspOut);
    chk(64'({ppPadOe, ppPadOut & po}), 64'({po, pv & po}));
    chk(64'({sp1PadOe, sp1PadOut & s1}), 64'({s1, v1 & s1}));
    chk(64'({sp0PadOe, sp0PadOut & s0}), 64'({s0, v0 & s0}));
    chk(64'({addrPadOe, addrPadOut}), 64'({(s & addrGpioOe) | ~s,
      (s & addrGpioOut) | (~s & ext_mem_addr)}));
    chk(64'({hostIn, sdramIn, addrGpioIn}), 64'({(c[14:12] == 3'h0) ? ppPadIn : 28'h0,
      (c[14:12] != 3'h0 && c[14:12] != 3'h7) ? ppPadIn[6:0] : 7'h0, addrPadIn & s}));
    chk(64'({card1In, mcspiIn, gpioHiIn}), 64'({(c[11:10] == 2'h0) ? sp1PadIn : 6'h0,
      (c[11:10] == 2'h1) ? sp1PadIn : 6'h0, (c[11:10] == 2'h2) ? sp1PadIn : 6'h0}));
    chk(64'({spiIn, ppGpioIn, uartIn, i2s2In, i2s3In}),
      64'(ppIn(c[14:12], ppPadIn)));
    chk(64'({i2s0In, gpioLoIn}), 64'({(c[9:8] == 2'h1) ? sp0PadIn[3:0] : 4'h0,
      (c[9:8] == 2'h2) ? sp0PadIn : 6'h0})
      | 64'((c[9:8] == 2'h1) ? {sp0PadIn[5:4], 4'h0} : 6'h0));
    chk(64'({card0In, bspIn, bsp_source_clock}), 64'({(c[9:8] == 2'h0) ? sp0PadIn : 6'h0,
      (c[9:8] == 2'h3) ? {sp0PadIn[5] & ~c[15], sp0PadIn[4:0]} : 6'h0,
      c[9:8] == 2'h3 && c[15] && sp0PadIn[5]}));
  endtask

  // main sequence
  initial begin
    seed = 32'h8f2949e6;
    err_total = 0;
    n_tests = 0;
    ioReq = '0;
    pool = '0;
    drive();
    rstPulse();
    #1;
    chk(64'(addrPadOe), 64'h0);
    @(posedge clock);
    rd(EPR_CTRL_ADDR, 16'h103f);
    // an unmapped write, then write and read back to back, then an unmapped read must read zero
    wr(EPR_CTRL_ADDR + 16'h0001, 16'hffff);
    io(1'b1, EPR_CTRL_ADDR, 16'hffff);
    rd(EPR_CTRL_ADDR, 16'hff3f);
    rd(EPR_CTRL_ADDR + 16'h0001, 16'h0000);
    // sweep all mode codes first, then fully random settings
    for (int i = 0; i < 40; i++) begin
      for (int k = 0; k < 9; k++) pool[k*32 +: 32] = $random(seed);
      drive();
      regVal = (i < 16) ? {i[3], i[2:0], i[1:0], i[1:0], pool[279:272] & {2'h3, {6{i[0]}}}}
                        : pool[287:272];
      wr(EPR_CTRL_ADDR, regVal);
      repeat (2) @(posedge clock);
      #1;
      check(regVal);
      @(posedge clock);
      rd(EPR_CTRL_ADDR, {regVal[15:8], 2'h0, regVal[5:0]});
    end
    rstPulse();
    rd(EPR_CTRL_ADDR, 16'h103f);
    give_verdict();
  end

  // a hang is cut short well past the expected run length
  initial begin
    repeat (2000) @(posedge clock);
    err_total++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
endmodule // tb
`default_nettype wire
